// File: lsw_cfg.svh
// Constants of the serial display write port
`ifndef LSW_CFG_SVH
`define LSW_CFG_SVH
`define LSW_WORD_BITS      4'h8
`define LSW_COLS           8'hf0
`define LSW_ROWS           8'hf0
`define LSW_LAST_COORD     8'hef
`define LSW_CMD_COL_WIN    8'h2a
`define LSW_CMD_ROW_WIN    8'h2b
`define LSW_CMD_MEM_WRITE  8'h2c
`define LSW_CMD_SCAN_MODE  8'h36
`define LSW_SCAN_ROW_BIT   7
`define LSW_SCAN_COL_BIT   6
`define LSW_SCAN_RESET     8'h00
`define LSW_RED_MSB        15
`define LSW_RED_LSB        11
`define LSW_GRN_MSB        10
`define LSW_GRN_LSB        5
`define LSW_BLU_MSB        4
`define LSW_BLU_LSB        0
`endif

// File: lsw_pkg.sv
// Types of the serial display write port
package lsw_pkg;
  typedef struct packed {
    logic       is_data;
    logic [7:0] value;
  } lsw_word_s;
  typedef struct packed {
    logic [7:0]  col;
    logic [7:0]  row;
    logic [15:0] color;
  } lsw_pixel_s;
  typedef enum logic [2:0] {
    ST_IDLE, ST_COL_WIN, ST_ROW_WIN, ST_SCAN, ST_PIXEL
  } lsw_state_e;
endpackage

// File: lsw_buf2.sv
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
module lsw_buf2
(
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset,
  // Fill side
  input  wire logic               in_valid,
  output logic                    in_ready,
  input  wire lsw_pkg::lsw_word_s in_word,
  // Drain side
  output logic                    out_valid,
  input  wire logic               out_ready,
  output lsw_pkg::lsw_word_s      out_word
);
  lsw_pkg::lsw_word_s mem_q [2];
  logic               wr_ptr_q;
  logic               rd_ptr_q;
  logic [1:0]         count_q;
  wire                push = in_valid && in_ready;
  wire                pop  = out_valid && out_ready;

  assign in_ready  = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_word  = mem_q[rd_ptr_q];

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_word;
    end
    if (reset)
    begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= ~wr_ptr_q;
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // lsw_buf2

// File: lsw_serial_port.sv
// Serial display write port: receiver, word decoder and pixel addresser
`timescale 1ns/1ps
`include "lsw_cfg.svh"
module lsw_serial_port
(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                reset,
  // Serial pins, input only
  input  wire logic                chip_select_n,
  input  wire logic                cmd_data_select,
  input  wire logic                serial_clk,
  input  wire logic                serial_data,
  input  wire logic                hw_init_n,
  input  wire logic                lamp_enable,
  // Backlight drive
  output logic                     lamp_drive,
  // Pixel write stream
  output logic                     pixel_valid,
  input  wire logic                pixel_ready,
  output lsw_pkg::lsw_pixel_s      pixel_out,
  // Command stream
  output logic                     cmd_strobe,
  output logic [7:0]               cmd_code
);
  // ***************************************************
  // Pin synchronisers
  // ***************************************************
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  always_ff @(posedge core_clk)
  begin
    sync1_q <= {lamp_enable, hw_init_n, serial_data, serial_clk, cmd_data_select,
                chip_select_n};
    sync2_q <= sync1_q;
  end
  wire cs_n_s  = sync2_q[0];
  wire dc_s    = sync2_q[1];
  wire sck_s   = sync2_q[2];
  wire sda_s   = sync2_q[3];
  wire init_s  = sync2_q[4];
  wire lamp_s  = sync2_q[5];
  wire rst_all = reset || !init_s;

  // ***************************************************
  // Bit receiver
  // ***************************************************
  logic       sck_prev_q;
  logic [6:0] shift_q;
  logic [2:0] bit_cnt_q;
  logic       word_valid_q;
  lsw_pkg::lsw_word_s word_q;
  logic       buf_in_ready;
  wire        sck_rise  = sck_s && !sck_prev_q;
  wire        take_bit  = sck_rise && !cs_n_s;
  wire        last_bit  = (bit_cnt_q == 3'h7);
  wire        word_done = take_bit && last_bit;

  always_ff @(posedge core_clk)
  begin
    sck_prev_q <= sck_s;
    if (rst_all || cs_n_s)
    begin
      bit_cnt_q <= 3'h0;
      shift_q   <= 7'h00;
    end
    else if (take_bit)
    begin
      shift_q   <= {shift_q[5:0], sda_s};
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst_all)
    begin
      word_valid_q <= 1'b0;
      word_q       <= '0;
    end
    else if (word_done && buf_in_ready)
    begin
      word_valid_q <= 1'b1;
      word_q       <= '{is_data: dc_s, value: {shift_q, sda_s}};
    end
    else
    begin
      word_valid_q <= 1'b0;
    end
  end

  // ***************************************************
  // Word buffer
  // ***************************************************
  logic               bw_valid;
  logic               bw_ready;
  lsw_pkg::lsw_word_s bw_word;
  lsw_buf2 u_buf
  (
    .core_clk  (core_clk),
    .reset     (rst_all),
    .in_valid  (word_valid_q),
    .in_ready  (buf_in_ready),
    .in_word   (word_q),
    .out_valid (bw_valid),
    .out_ready (bw_ready),
    .out_word  (bw_word)
  );

  // ***************************************************
  // Word decoder and address stepper
  // ***************************************************
  lsw_pkg::lsw_state_e state_q;
  logic [1:0]  arg_cnt_q;
  logic [7:0]  col_lo_q, col_hi_q, row_lo_q, row_hi_q;
  logic [7:0]  col_q, row_q;
  logic [7:0]  scan_q;
  logic        byte_hi_q;
  logic [7:0]  color_hi_q;
  logic        pix_valid_q;
  lsw_pkg::lsw_pixel_s pix_q;
  logic        cmd_strobe_q;
  logic [7:0]  cmd_code_q;
  logic        lamp_q;

  wire        pix_stall = pix_valid_q && !pixel_ready;
  assign      bw_ready  = !pix_stall;
  wire        take_word = bw_valid && bw_ready;
  wire        is_cmd    = take_word && !bw_word.is_data;
  wire        is_data   = take_word && bw_word.is_data;
  wire [7:0]  arg_clamp = (bw_word.value > `LSW_LAST_COORD) ? `LSW_LAST_COORD
                                                            : bw_word.value;
  wire        col_dec   = scan_q[`LSW_SCAN_COL_BIT];
  wire        row_dec   = scan_q[`LSW_SCAN_ROW_BIT];
  wire [7:0]  col_start = col_dec ? col_hi_q : col_lo_q;
  wire [7:0]  col_end   = col_dec ? col_lo_q : col_hi_q;
  wire [7:0]  row_start = row_dec ? row_hi_q : row_lo_q;
  wire [7:0]  row_end   = row_dec ? row_lo_q : row_hi_q;
  wire        col_wrap  = (col_q == col_end);
  wire        row_wrap  = (row_q == row_end);
  wire [7:0]  col_step  = col_dec ? col_q - 8'h01 : col_q + 8'h01;
  wire [7:0]  row_step  = row_dec ? row_q - 8'h01 : row_q + 8'h01;
  wire [7:0]  col_next  = col_wrap ? col_start : col_step;
  wire [7:0]  row_next  = col_wrap ? (row_wrap ? row_start : row_step) : row_q;
  wire        pix_done  = is_data && (state_q == lsw_pkg::ST_PIXEL) && byte_hi_q;

  always_ff @(posedge core_clk)
  begin
    if (rst_all)
    begin
      state_q      <= lsw_pkg::ST_IDLE;
      arg_cnt_q    <= 2'h0;
      col_lo_q     <= 8'h00;
      col_hi_q     <= `LSW_LAST_COORD;
      row_lo_q     <= 8'h00;
      row_hi_q     <= `LSW_LAST_COORD;
      col_q        <= 8'h00;
      row_q        <= 8'h00;
      scan_q       <= `LSW_SCAN_RESET;
      byte_hi_q    <= 1'b0;
      color_hi_q   <= 8'h00;
      cmd_strobe_q <= 1'b0;
      cmd_code_q   <= 8'h00;
    end
    else
    begin
      cmd_strobe_q <= is_cmd;
      if (is_cmd)
      begin
        cmd_code_q <= bw_word.value;
        arg_cnt_q  <= 2'h0;
        byte_hi_q  <= 1'b0;
        case (bw_word.value)
          `LSW_CMD_COL_WIN:   state_q <= lsw_pkg::ST_COL_WIN;
          `LSW_CMD_ROW_WIN:   state_q <= lsw_pkg::ST_ROW_WIN;
          `LSW_CMD_SCAN_MODE: state_q <= lsw_pkg::ST_SCAN;
          `LSW_CMD_MEM_WRITE:
          begin
            state_q <= lsw_pkg::ST_PIXEL;
            col_q   <= col_start;
            row_q   <= row_start;
          end
          default:            state_q <= lsw_pkg::ST_IDLE;
        endcase
      end
      else if (is_data)
      begin
        arg_cnt_q <= arg_cnt_q + 2'h1;
        case (state_q)
          lsw_pkg::ST_COL_WIN:
          begin
            if (arg_cnt_q == 2'h1)
              col_lo_q <= arg_clamp;
            if (arg_cnt_q == 2'h3)
              col_hi_q <= arg_clamp;
          end
          lsw_pkg::ST_ROW_WIN:
          begin
            if (arg_cnt_q == 2'h1)
              row_lo_q <= arg_clamp;
            if (arg_cnt_q == 2'h3)
              row_hi_q <= arg_clamp;
          end
          lsw_pkg::ST_SCAN:
            scan_q <= bw_word.value;
          lsw_pkg::ST_PIXEL:
          begin
            byte_hi_q <= ~byte_hi_q;
            if (!byte_hi_q)
              color_hi_q <= bw_word.value;
            else
            begin
              col_q <= col_next;
              row_q <= row_next;
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst_all)
    begin
      pix_valid_q <= 1'b0;
      pix_q       <= '0;
    end
    else if (pix_done)
    begin
      pix_valid_q <= 1'b1;
      pix_q       <= '{col: col_q, row: row_q, color: {color_hi_q, bw_word.value}};
    end
    else if (pixel_ready)
    begin
      pix_valid_q <= 1'b0;
    end
  end

  // ***************************************************
  // Backlight
  // ***************************************************
  always_ff @(posedge core_clk)
  begin
    if (reset)
      lamp_q <= 1'b0;
    else
      lamp_q <= lamp_s;
  end

  assign lamp_drive  = lamp_q;
  assign pixel_valid = pix_valid_q;
  assign pixel_out   = pix_q;
  assign cmd_strobe  = cmd_strobe_q;
  assign cmd_code    = cmd_code_q;
endmodule // lsw_serial_port

// File: lsw_host_model.sv
// Serial host model for the display write port
`timescale 1ns/1ps
module lsw_host_model
(
  // Serial pins
  output logic chip_select_n,
  output logic cmd_data_select,
  output logic serial_clk,
  output logic serial_data
);
  initial
  begin
    chip_select_n = 1'b1;
    cmd_data_select = 1'b0;
    serial_clk = 1'b0;
    serial_data = 1'b0;
  end
  // One word; sel_on low keeps chip select high
  task automatic send(input logic dc, input logic [7:0] b, input logic sel_on);
    chip_select_n = !sel_on;
    cmd_data_select = dc;
    #0.5;
    for (int i = 7; i >= 0; i--)
    begin
      serial_data = b[i];
      #31;
      serial_clk = 1'b1;
      #63;
      serial_clk = 1'b0;
      #31;
    end
    chip_select_n = 1'b1;
    serial_data = !b[0];
    #103.5;
  endtask
endmodule // lsw_host_model

// File: lsw_serial_port_assertions.sv
// Assertion checker for the display write port
`timescale 1ns/1ps
module lsw_chk
(
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                reset,
  // Pins
  input wire logic                chip_select_n,
  input wire logic                serial_clk,
  input wire logic                hw_init_n,
  input wire logic                lamp_enable,
  input wire logic                lamp_drive,
  // Streams
  input wire logic                pixel_valid,
  input wire logic                pixel_ready,
  input wire lsw_pkg::lsw_pixel_s pixel_out,
  input wire logic                cmd_strobe,
  input wire logic [7:0]          cmd_code
);
  logic       sclk_q;
  logic [3:0] quiet_q;
  logic [3:0] cs_hi_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  always_ff @(posedge core_clk)
  begin
    sclk_q <= serial_clk;
    quiet_q <= (reset || (serial_clk && !sclk_q)) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
    cs_hi_q <= (reset || !chip_select_n) ? 4'h0 : cs_hi_q + {3'h0, cs_hi_q != 4'hf};
  end
  sequence s_stalled;
    pixel_valid && !pixel_ready;
  endsequence
  sequence s_init_up;
    hw_init_n [*6];
  endsequence
  a_strobe_pulse: assert property (cmd_strobe |=> !cmd_strobe)
    else $error("command strobe longer than one cycle");
  a_strobe_clk: assert property (cmd_strobe |-> quiet_q < 4'hc)
    else $error("command strobe without serial clock edge");
  a_strobe_cs: assert property (cmd_strobe |-> cs_hi_q < 4'hc)
    else $error("command strobe without chip select");
  a_valid_hold: assert property (s_stalled |=> pixel_valid && $stable(pixel_out))
    else $error("pixel dropped or changed while stalled");
  a_window_bound: assert property (pixel_valid |-> pixel_out.col <= 8'hef
    && pixel_out.row <= 8'hef)
    else $error("pixel outside array");
  a_init_quiet: assert property (!hw_init_n [*5] |-> !cmd_strobe && !pixel_valid)
    else $error("output active in init");
  a_code_hold: assert property (s_init_up ##0 !cmd_strobe |-> $stable(cmd_code))
    else $error("command code changed without strobe");
  a_lamp_follow: assert property (!$past(reset) && !$past(reset, 2)
    && !$past(reset, 3) |-> lamp_drive == $past(lamp_enable, 3))
    else $error("lamp drive does not follow enable");
endmodule // lsw_chk
bind lsw_serial_port lsw_chk u_chk (.core_clk(core_clk), .reset(reset),
  .chip_select_n(chip_select_n), .serial_clk(serial_clk), .hw_init_n(hw_init_n),
  .lamp_enable(lamp_enable), .lamp_drive(lamp_drive), .pixel_valid(pixel_valid),
  .pixel_ready(pixel_ready), .pixel_out(pixel_out), .cmd_strobe(cmd_strobe),
  .cmd_code(cmd_code));

// File: tb.sv
// Testbench of the display write port
`timescale 1ns/1ps
module tb;
  logic core_clk, reset, hw_init_n, lamp_enable, pixel_ready, lamp_drive;
  logic chip_select_n, cmd_data_select, serial_clk, serial_data;
  logic pixel_valid, cmd_strobe;
  logic [7:0] cmd_code, last_cmd;
  lsw_pkg::lsw_pixel_s pixel_out;
  lsw_pkg::lsw_pixel_s pix_q[$];
  int n_mismatch, tests_run, n_cmd, cyc;
  lsw_host_model host (.chip_select_n(chip_select_n), .cmd_data_select(cmd_data_select),
    .serial_clk(serial_clk), .serial_data(serial_data));
  lsw_serial_port dut (.core_clk(core_clk), .reset(reset), .chip_select_n(chip_select_n),
    .cmd_data_select(cmd_data_select), .serial_clk(serial_clk), .serial_data(serial_data),
    .hw_init_n(hw_init_n), .lamp_enable(lamp_enable), .lamp_drive(lamp_drive),
    .pixel_valid(pixel_valid), .pixel_ready(pixel_ready), .pixel_out(pixel_out),
    .cmd_strobe(cmd_strobe), .cmd_code(cmd_code));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = !core_clk;
  end
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (pixel_valid && pixel_ready)
      pix_q.push_back(pixel_out);
    if (cmd_strobe)
    begin
      n_cmd++;
      last_cmd = cmd_code;
    end
    if (cyc == 30000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk_v(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pix(string nm, lsw_pkg::lsw_pixel_s e, lsw_pkg::lsw_pixel_s g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic t_lamp();
    @(negedge core_clk) lamp_enable = 1'b1;
    repeat (4) @(negedge core_clk);
    chk_v("lamp on", 8'h01, {7'h0, lamp_drive});
    lamp_enable = 1'b0;
    repeat (4) @(negedge core_clk);
    chk_v("lamp off", 8'h00, {7'h0, lamp_drive});
    $display("Test lamp done");
  endtask
  task automatic t_cmds();
    logic [7:0] codes[4] = '{8'h2a, 8'h2b, 8'h2c, 8'h36};
    int k;
    foreach (codes[i])
    begin
      k = n_cmd;
      host.send(1'b0, codes[i], 1'b1);
      chk_v("cmd count", 8'(k + 1), 8'(n_cmd));
      chk_v("cmd code", codes[i], last_cmd);
    end
    host.send(1'b1, 8'h00, 1'b1);
    $display("Test commands done");
  endtask
  task automatic t_gate();
    int k;
    k = n_cmd;
    host.send(1'b0, 8'h2c, 1'b0);
    @(negedge core_clk) hw_init_n = 1'b0;
    host.send(1'b0, 8'h2b, 1'b1);
    @(negedge core_clk) hw_init_n = 1'b1;
    repeat (8) @(negedge core_clk);
    chk_v("gated cmds", 8'(k), 8'(n_cmd));
    host.send(1'b0, 8'h2b, 1'b1);
    chk_v("cmd after init", 8'h2b, last_cmd);
    $display("Test gating done");
  endtask
  task automatic pix_run(int n, logic [7:0] c0, c1, r0, r1, sc, logic stall);
    logic [7:0] a[10] = '{8'h2a, 8'h00, c0, 8'h00, c1, 8'h2b, 8'h00, r0, 8'h00, r1};
    logic [7:0] x, y, hc, hr, cs, ce, rs, re;
    logic [15:0] c;
    foreach (a[i])
      host.send(i % 5 != 0, a[i], 1'b1);
    host.send(1'b0, 8'h36, 1'b1);
    host.send(1'b1, sc, 1'b1);
    pix_q.delete();
    host.send(1'b0, 8'h2c, 1'b1);
    @(negedge core_clk) pixel_ready = !stall;
    for (int i = 0; i < n; i++)
    begin
      c = 16'ha5c3 + 16'h0101 * i[15:0];
      host.send(1'b1, c[15:8], 1'b1);
      host.send(1'b1, c[7:0], 1'b1);
      if (stall && i == 0)
      begin
        chk_v("valid held", 8'h01, {7'h0, pixel_valid});
        @(negedge core_clk) pixel_ready = 1'b1;
      end
    end
    repeat (20) @(negedge core_clk);
    chk_v("pixel count", 8'(n), 8'(pix_q.size()));
    hc = (c1 > 8'hef) ? 8'hef : c1;
    hr = (r1 > 8'hef) ? 8'hef : r1;
    cs = sc[6] ? hc : c0;
    ce = sc[6] ? c0 : hc;
    rs = sc[7] ? hr : r0;
    re = sc[7] ? r0 : hr;
    x = cs;
    y = rs;
    for (int i = 0; i < n; i++)
    begin
      chk_pix("pixel", {x, y, 16'ha5c3 + 16'h0101 * i[15:0]}, pix_q[i]);
      y = (x != ce) ? y : (y == re) ? rs : sc[7] ? y - 8'h01 : y + 8'h01;
      x = (x == ce) ? cs : sc[6] ? x - 8'h01 : x + 8'h01;
    end
  endtask
  initial
  begin
    reset = 1'b1;
    hw_init_n = 1'b1;
    lamp_enable = 1'b0;
    pixel_ready = 1'b1;
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    repeat (4) @(negedge core_clk);
    t_lamp();
    t_cmds();
    t_gate();
    pix_run(5, 8'h0a, 8'h0b, 8'h05, 8'h06, 8'h00, 1'b1);
    $display("Test pixels done");
    pix_run(3, 8'hee, 8'hfa, 8'hef, 8'hff, 8'h00, 1'b0);
    $display("Test clamp done");
    pix_run(4, 8'h10, 8'h11, 8'h20, 8'h21, 8'hc0, 1'b0);
    $display("Test scan done");
    wrap_up();
  end
endmodule // tb
